// ===== hw/cadc_map.vh
/*
  offsets, field positions, clamp limits and reset values for the
  charger converter result registers.
  assumes nothing; definitions only.
*/
`ifndef CADC_MAP_VH
`define CADC_MAP_VH
`define CADC_OFS_BATT_CURRENT   8'h2A
`define CADC_OFS_INPUT_VOLT     8'h2C
`define CADC_OFS_MID_VOLT       8'h2E
`define CADC_OFS_BATT_VOLT      8'h30
`define CADC_OFS_SYS_VOLT       8'h32
`define CADC_RESET_VALUE        16'h0000
`define CADC_CUR_LSB            2
`define CADC_HV_LSB             2
`define CADC_LV_LSB             1
`define CADC_CUR_POS_MAX        14'sh03E8
`define CADC_CUR_NEG_MIN        14'sh38AD
`define CADC_CUR_ABORT          14'h2000
`define CADC_HV_MAX             13'h11B6
`define CADC_LV_MAX             12'h0AF0
`define CADC_CH_CUR             0
`define CADC_CH_IN              1
`define CADC_CH_MID             2
`define CADC_CH_BAT             3
`define CADC_CH_SYS             4
`endif

// ===== hw/cadc_results.v
/*
  charger converter result register bank: five read-only results built
  from raw conversion samples, with clamping, sign rules and abort code.
  assumes raw samples arrive as one-cycle strobes in core_clk_i domain
  from the converter; the host byte reads come from the serial slave.
*/
// Functional notes
// - current is signed, bits 15:2, 4 mA
// - charging positive, discharging negative
// - charge disabled forces current to zero
// - current clamped to codes 38AD..3E8
// - forward mode nonnegative, battery mode nonpositive
// - polarity flip mid conversion gives 0x8000
// - input voltage bits 14:2, clamp 11B6
// - midpoint voltage bits 14:2, clamp 11B6
// - battery voltage bits 12:1, clamp AF0
// - system voltage bits 12:1, clamp AF0
// - reset zero, reserved zero, writes ignored
// - results held; only charge disable clears one, the current
// - per-channel disable ignores its samples, result held
`timescale 1ns/10ps
`include "cadc_map.vh"
module cadc_results
(
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire        charge_enable_bit_i,
  input  wire        forward_mode_i,
  input  wire [4:0]  channel_off_i,
  input  wire        cur_done_i,
  input  wire        cur_flip_i,
  input  wire [15:0] cur_raw_i,
  input  wire        in_done_i,
  input  wire [15:0] in_raw_i,
  input  wire        mid_done_i,
  input  wire [15:0] mid_raw_i,
  input  wire        bat_done_i,
  input  wire [15:0] bat_raw_i,
  input  wire        sys_done_i,
  input  wire [15:0] sys_raw_i,
  input  wire        rd_start_i,
  input  wire        rd_byte_i,
  input  wire [7:0]  rd_addr_i,
  input  wire        wr_i,
  input  wire [7:0]  wr_data_i,
  output reg  [7:0]  rd_data_o,
  output reg         rd_hit_o
);
  ////////////////////////////////////////////////////////////////////////
  // result registers
  reg  [13:0]        battery_current_field_r;
  reg                cur_flip_seen_r;
  reg  signed [15:0] cur_s;
  reg  [13:0]        cur_clamp;
  reg  [13:0]        cur_signed;
  reg  [13:0]        cur_nxt;
  wire [12:0]        input_voltage_field;
  wire [12:0]        midpoint_voltage_field;
  wire [12:0]        battery_voltage_field;
  wire [12:0]        system_voltage_field;
  wire [3:0]         volt_done;
  wire [3:0]         volt_off;
  wire [63:0]        volt_raw;
  wire [51:0]        volt_field;

  ////////////////////////////////////////////////////////////////////////
  // current conversion: clamp to the reportable range
  always @*
  begin
    cur_s     = cur_raw_i;
    cur_clamp = cur_s[13:0];
    if (cur_s > $signed({2'b00, `CADC_CUR_POS_MAX}))
    begin
      cur_clamp = `CADC_CUR_POS_MAX;
    end
    else if (cur_s < $signed({2'b11, `CADC_CUR_NEG_MIN}))
    begin
      cur_clamp = `CADC_CUR_NEG_MIN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // current conversion: wrong sign for the mode reads as zero
  always @*
  begin
    cur_signed = cur_clamp;
    if (forward_mode_i && cur_raw_i[15])
    begin
      cur_signed = 14'h0000;
    end
    else if (!forward_mode_i && !cur_raw_i[15] &&
             (cur_raw_i != 16'h0000))
    begin
      cur_signed = 14'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // current conversion: polarity flip aborts the conversion
  always @*
  begin
    cur_nxt = cur_signed;
    if (cur_flip_i || cur_flip_seen_r)
    begin
      cur_nxt = `CADC_CUR_ABORT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // abort tracking: a flip is remembered until its conversion ends
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cur_flip_seen_r <= 1'b0;
    end
    else if (cur_done_i)
    begin
      cur_flip_seen_r <= 1'b0;
    end
    else if (cur_flip_i)
    begin
      cur_flip_seen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // current field
  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      battery_current_field_r <= 14'h0000;
    end
    else if (!charge_enable_bit_i)
    begin
      battery_current_field_r <= 14'h0000;
    end
    else if (cur_done_i && !channel_off_i[`CADC_CH_CUR])
    begin
      battery_current_field_r <= cur_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // voltage channels gathered for the per-channel loop
  assign volt_done = {sys_done_i, bat_done_i, mid_done_i, in_done_i};
  assign volt_off  = channel_off_i[`CADC_CH_SYS:`CADC_CH_IN];
  assign volt_raw  = {sys_raw_i, bat_raw_i, mid_raw_i, in_raw_i};

  ////////////////////////////////////////////////////////////////////////
  // voltage channels: unsigned, clamped at the top, held between samples
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_volt
      reg  [12:0] field_r;
      wire [15:0] raw;
      wire [15:0] top;
      wire        over;
      wire        take;
      assign raw  = volt_raw[16*ch+15:16*ch];
      assign top  = (ch < 2) ? {3'b000, `CADC_HV_MAX} :
                               {4'h0, `CADC_LV_MAX};
      assign over = (raw > top);
      assign take = volt_done[ch] && !volt_off[ch];
      always @(posedge core_clk_i)
      begin
        if (rst_i)
        begin
          field_r <= 13'h0000;
        end
        else if (take)
        begin
          if (over)
          begin
            field_r <= top[12:0];
          end
          else
          begin
            field_r <= raw[12:0];
          end
        end
        // no other path: the value stays until the next sample
      end
      assign volt_field[13*ch+12:13*ch] = field_r;
    end
  endgenerate

  assign input_voltage_field    = volt_field[12:0];
  assign midpoint_voltage_field = volt_field[25:13];
  assign battery_voltage_field  = volt_field[38:26];
  assign system_voltage_field   = volt_field[51:39];

  ////////////////////////////////////////////////////////////////////////
  // register view: fields at their bit positions, reserved bits zero
  reg  [15:0] in_sel;
  reg  [15:0] mid_sel;
  reg  [15:0] bat_sel;
  reg  [15:0] sys_sel;
  reg  [15:0] word_sel;
  reg         word_hit;
  reg         byte_idx_r;
  wire [15:0] snap;

  always @*
  begin
    in_sel  = {1'b0, input_voltage_field, 2'b00};
    mid_sel = {1'b0, midpoint_voltage_field, 2'b00};
    bat_sel = {3'b000, battery_voltage_field[11:0], 1'b0};
    sys_sel = {3'b000, system_voltage_field[11:0], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode
  always @*
  begin
    word_sel = 16'h0000;
    word_hit = 1'b1;
    if (rd_addr_i == `CADC_OFS_BATT_CURRENT)
    begin
      word_sel = {battery_current_field_r, 2'b00};
    end
    else if (rd_addr_i == `CADC_OFS_INPUT_VOLT)
    begin
      word_sel = in_sel;
    end
    else if (rd_addr_i == `CADC_OFS_MID_VOLT)
    begin
      word_sel = mid_sel;
    end
    else if (rd_addr_i == `CADC_OFS_BATT_VOLT)
    begin
      word_sel = bat_sel;
    end
    else if (rd_addr_i == `CADC_OFS_SYS_VOLT)
    begin
      word_sel = sys_sel;
    end
    else
    begin
      word_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path: first byte live, later bytes from the snapshot
  cadc_snap u_snap
  (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .load_i     (rd_start_i),
    .value_i    (word_sel),
    .snap_o     (snap)
  );

  always @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      rd_data_o  <= 8'h00;
      rd_hit_o   <= 1'b0;
      byte_idx_r <= 1'b0;
    end
    else if (rd_start_i)
    begin
      rd_data_o  <= word_sel[15:8];
      rd_hit_o   <= word_hit;
      byte_idx_r <= 1'b1;
    end
    else if (rd_byte_i)
    begin
      byte_idx_r <= ~byte_idx_r;
      if (byte_idx_r)
      begin
        rd_data_o <= snap[7:0];
      end
      else
      begin
        rd_data_o <= snap[15:8];
      end
    end
    // writes (wr_i, wr_data_i) deliberately have no effect
  end
endmodule

// ===== hw/cadc_snap.v
/*
  read snapshot holder: latches a 16-bit register value when the first
  byte of a read is taken, so the second byte comes from the same value.
  assumes the main file signals the start of each two-byte read.
*/
`timescale 1ns/10ps
`include "cadc_map.vh"
module cadc_snap
(
  input  wire        core_clk_i,
  input  wire        rst_i,
  input  wire        load_i,
  input  wire [15:0] value_i,
  output reg  [15:0] snap_o
);
  always @(posedge core_clk_i)
  begin
    if (rst_i)
      snap_o <= `CADC_RESET_VALUE;
    else if (load_i)
      snap_o <= value_i;
  end
endmodule

// ===== verif/cadc_host.sv
/* host model: byte reads and writes of the result bank.
   assumes the read strobes of cadc_results. */
`timescale 1ns/10ps
module cadc_host (input wire clk_i, input wire [7:0] d_i,
  output reg st_o, by_o, wr_o, output reg [7:0] a_o);
  initial begin st_o = 0; by_o = 0; wr_o = 0; a_o = 0; end
  task hi(input [7:0] a, output [7:0] v);
    begin @(posedge clk_i) st_o <= 1; a_o <= a;
      @(posedge clk_i) st_o <= 0; #1 v = d_i; end
  endtask
  task lo(output [7:0] v);
    begin @(posedge clk_i) by_o <= 1;
      @(posedge clk_i) by_o <= 0; #1 v = d_i; end
  endtask
  task rd(input [7:0] a, output [15:0] v);
    begin hi(a, v[15:8]); lo(v[7:0]); end
  endtask
  task wr;
    begin @(posedge clk_i) wr_o <= 1; a_o <= 8'hFF;
      @(posedge clk_i) wr_o <= 0; end
  endtask
endmodule

// ===== verif/cadc_props.sv
/* checker on the result bank read port.
   assumes it is bound into cadc_results. */
`timescale 1ns/10ps
module cadc_props (
  input wire       core_clk_i, rst_i, charge_enable_bit_i,
  input wire       rd_start_i, rd_byte_i,
  input wire [7:0] rd_addr_i, rd_data_o,
  input wire       rd_hit_o
);
  reg  [7:0] la;
  wire mp = rd_addr_i inside {8'h2A, 8'h2C, 8'h2E, 8'h30, 8'h32};
  always @(posedge core_clk_i)
    if (rst_i) la <= 8'h00;
    else if (rd_start_i) la <= rd_addr_i;
    else if (rd_byte_i) la <= 8'h00;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  unmapped_read_a: assert property (rd_start_i && !mp |=>
    !rd_hit_o && rd_data_o == 8'h00) else $error("unmapped read");
  mapped_hit_a: assert property (rd_start_i && mp |=> rd_hit_o)
    else $error("mapped miss");
  reset_clear_a: assert property (disable iff (1'b0) rst_i |=>
    rd_data_o == 8'h00 && !rd_hit_o) else $error("reset value");
  low_reserved_a: assert property (rd_byte_i && la[7:4] == 4'h2 |=>
    rd_data_o[1:0] == 2'b00) else $error("low bits set");
  lv_low_a: assert property (rd_byte_i && la[7:4] == 4'h3 |=>
    !rd_data_o[0]) else $error("bit0 set");
  hv_top_a: assert property (rd_start_i && rd_addr_i[7:4] == 4'h2
    && rd_addr_i != 8'h2A |=> rd_data_o <= 8'h46) else $error("hv top");
  lv_top_a: assert property (rd_start_i && rd_addr_i[7:4] == 4'h3
    |=> rd_data_o <= 8'h15) else $error("lv top");
  charge_off_a: assert property (!charge_enable_bit_i
    && $past(!charge_enable_bit_i) && rd_start_i && rd_addr_i == 8'h2A
    |=> rd_data_o == 8'h00) else $error("charge off");
  cover property (rd_start_i && mp);
  cover property (rd_byte_i && la != 8'h00);
  cover property (!charge_enable_bit_i && rd_start_i);
endmodule
bind cadc_results cadc_props chk (.core_clk_i, .rst_i,
  .charge_enable_bit_i, .rd_start_i, .rd_byte_i, .rd_addr_i,
  .rd_data_o, .rd_hit_o);

// ===== verif/cadc_results_tb.sv
/* self-checking bench for cadc_results.
   assumes the host model cadc_host. */
`timescale 1ns/10ps
module cadc_results_tb;
  reg        clk = 0, rst = 1, ce = 1, fw = 1, fl = 0;
  reg  [4:0] dn = 0, off = 0;
  reg  [15:0] raw = 0, v;
  wire [7:0] d, a;
  wire       st, by, wr, hit;
  int        error_cnt = 0, comparisons = 0, i;
  initial forever #10 clk = ~clk;
  cadc_host host (.clk_i(clk), .d_i(d), .st_o(st), .by_o(by), .wr_o(wr),
    .a_o(a));
  cadc_results uut (.core_clk_i(clk), .rst_i(rst),
    .charge_enable_bit_i(ce), .forward_mode_i(fw), .channel_off_i(off),
    .cur_done_i(dn[0]), .cur_flip_i(fl), .cur_raw_i(raw),
    .in_done_i(dn[1]), .in_raw_i(raw), .mid_done_i(dn[2]),
    .mid_raw_i(raw), .bat_done_i(dn[3]), .bat_raw_i(raw),
    .sys_done_i(dn[4]), .sys_raw_i(raw), .rd_start_i(st), .rd_byte_i(by),
    .rd_addr_i(a), .wr_i(wr), .wr_data_i(a), .rd_data_o(d), .rd_hit_o(hit));
  task chk(input string n, input [15:0] e, g);
    begin comparisons++; if (e !== g) begin error_cnt++;
      $display("BAD %s exp %h got %h", n, e, g); end end
  endtask
  task rc(input [7:0] ad, input [15:0] e);
    begin host.rd(ad, v); chk($sformatf("reg %h", ad), e, v); end
  endtask
  task put(input [2:0] c, input [15:0] r, input f = 0);
    begin @(posedge clk) raw <= r; dn <= 5'h01 << c; fl <= f;
      @(posedge clk) dn <= 0; fl <= 0; @(posedge clk); end
  endtask
  task results;
    begin $display("errors %0d of %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish; end
  endtask
  initial begin #100000; error_cnt++; results; end
  initial begin
    repeat (20) @(posedge clk); rst <= 0;
    for (i = 'h2A; i <= 'h34; i += 2) rc(i[7:0], 16'h0000);
    chk("hit", 16'h0000, {15'h0000, hit});
    put(0, 16'h0064); rc(8'h2A, 16'h0190);
    put(0, 16'h05DC); rc(8'h2A, 16'h0FA0);
    put(0, 16'hFFEC); rc(8'h2A, 16'h0000);
    fw <= 0; put(0, 16'hF830); rc(8'h2A, 16'hE2B4);
    put(0, 16'hFFF6); rc(8'h2A, 16'hFFD8);
    put(0, 16'h0005); rc(8'h2A, 16'h0000);
    put(0, 16'hFFF6, 1); rc(8'h2A, 16'h8000);
    @(posedge clk) fl <= 1; @(posedge clk) fl <= 0;
    put(0, 16'hFFF6); rc(8'h2A, 16'h8000);
    put(0, 16'hFFF6); rc(8'h2A, 16'hFFD8);
    ce <= 0; put(0, 16'hFFF6); rc(8'h2A, 16'h0000);
    ce <= 1; put(1, 16'h2000); rc(8'h2C, 16'h46D8);
    off <= 5'h02; put(1, 16'h0005); rc(8'h2C, 16'h46D8);
    off <= 0; put(2, 16'h0001); rc(8'h2E, 16'h0004);
    put(3, 16'hFFFF); rc(8'h30, 16'h15E0);
    put(4, 16'h0123); host.wr(); rc(8'h32, 16'h0246);
    host.hi(8'h2E, v[15:8]); put(2, 16'h0400); host.lo(v[7:0]);
    chk("tear", 16'h0004, v);
    rc(8'h2E, 16'h1000);
    results;
  end
endmodule
